// ===== inc/pcrsd_pkg.sv
package pcrsd_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int CTRL_WAIT_NS = 500;
    localparam int CTRL_WAIT_CYC = (CTRL_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int REF_WINDOW_NS = 10000;
    // master-clock cycles per window = ratio * fs_khz / KHZ_SCALE
    localparam int KHZ_SCALE = 1000000 / REF_WINDOW_NS;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int CNT_W = 12;
    localparam int DIV_W = 4;
    localparam int OS_W = 8;
    localparam int WAIT_W = 6;

    // ------------------------------------------------------------
    // supported clock ratios
    // ------------------------------------------------------------
    localparam logic [CNT_W-1:0] R64 = 12'h040;
    localparam logic [CNT_W-1:0] R96 = 12'h060;
    localparam logic [CNT_W-1:0] R128 = 12'h080;
    localparam logic [CNT_W-1:0] R192 = 12'h0C0;
    localparam logic [CNT_W-1:0] R256 = 12'h100;
    localparam logic [CNT_W-1:0] R384 = 12'h180;
    localparam logic [CNT_W-1:0] R512 = 12'h200;
    localparam logic [CNT_W-1:0] R768 = 12'h300;
    localparam logic [CNT_W-1:0] R1024 = 12'h400;
    localparam logic [CNT_W-1:0] R1152 = 12'h480;

    // ------------------------------------------------------------
    // auto-detect frame rate bands, kHz
    // ------------------------------------------------------------
    localparam int SSM_LO_KHZ = 4;
    localparam int SSM_HI_KHZ = 54;
    localparam int DSM_LO_KHZ = 84;
    localparam int DSM_HI_KHZ = 108;
    localparam int QSM_LO_KHZ = 170;
    localparam int QSM_HI_KHZ = 216;
    localparam int R1152_LO_KHZ = 30;
    localparam int R1152_HI_KHZ = 34;

    // ------------------------------------------------------------
    // oversampling per mode
    // ------------------------------------------------------------
    localparam logic [OS_W-1:0] OS_SINGLE = 8'h80;
    localparam logic [OS_W-1:0] OS_DOUBLE = 8'h40;
    localparam logic [OS_W-1:0] OS_QUAD = 8'h20;
    localparam int OS_SH_SINGLE = 7;
    localparam int OS_SH_DOUBLE = 6;
    localparam int OS_SH_QUAD = 5;

    // ------------------------------------------------------------
    // mode select pin codes (bits 4:2) and software speed codes
    // ------------------------------------------------------------
    localparam logic [2:0] MSEL_SINGLE = 3'h0;
    localparam logic [2:0] MSEL_SINGLE_DEM = 3'h1;
    localparam logic [2:0] MSEL_DOUBLE = 3'h2;
    localparam logic [2:0] MSEL_QUAD = 3'h3;
    localparam logic [2:0] MSEL_AUTO = 3'h4;
    localparam logic [2:0] MSEL_AUTO_DEM = 3'h5;
    localparam logic [1:0] SWSEL_SINGLE = 2'h0;
    localparam logic [1:0] SWSEL_DOUBLE = 2'h1;
    localparam logic [1:0] SWSEL_QUAD = 2'h2;
    localparam logic [1:0] SWSEL_AUTO = 2'h3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PCRSD_SPD_SINGLE = 3'b001,
        PCRSD_SPD_DOUBLE = 3'b010,
        PCRSD_SPD_QUAD = 3'b100
    } pcrsd_speed_e;

    typedef enum logic [2:0] {
        PCRSD_ST_INIT = 3'b001,
        PCRSD_ST_MEASURE = 3'b010,
        PCRSD_ST_LOCKED = 3'b100
    } pcrsd_state_e;

    typedef struct packed {
        pcrsd_speed_e speed;
        logic [OS_W-1:0] os;
        logic [DIV_W-1:0] div;
        logic valid;
    } pcrsd_clkcfg_s;

    typedef struct packed {
        logic signed [31:0] word;
        logic right;
    } pcrsd_sample_s;

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------
    function automatic logic in_band(input logic [CNT_W-1:0] ratio, input logic [CNT_W-1:0] cnt,
                                     input int lo, input int hi);
        logic [23:0] scaled;
        scaled = 24'(cnt) * 24'(KHZ_SCALE);
        return (24'(ratio) * 24'(lo) <= scaled) && (scaled <= 24'(ratio) * 24'(hi));
    endfunction

    function automatic logic single_ratio(input logic [CNT_W-1:0] r);
        return (r == R256) || (r == R384) || (r == R512) || (r == R768) || (r == R1024);
    endfunction

    function automatic logic double_ratio(input logic [CNT_W-1:0] r);
        return (r == R128) || (r == R192) || (r == R256) || (r == R384) || (r == R512);
    endfunction

    function automatic logic quad_ratio(input logic [CNT_W-1:0] r);
        return (r == R64) || (r == R96) || (r == R128) || (r == R192) || (r == R256);
    endfunction

endpackage

// ===== design/pcrsd_divider.sv
`timescale 1ns/1ps
`default_nettype none

module pcrsd_divider
    import pcrsd_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic enable,
    input wire logic [DIV_W-1:0] div,
    output logic tick
);

    logic [DIV_W-1:0] cnt_reg;
    logic [DIV_W-1:0] cnt_next;
    logic tick_next;
    wire logic wrap = (cnt_reg >= div - DIV_W'(1));

    assign cnt_next = (!enable || wrap) ? '0 : cnt_reg + DIV_W'(1);
    assign tick_next = enable && wrap;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick <= tick_next;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_div_spacing: assert property (@(posedge clk) disable iff (!arst_n)
        tick && enable && $stable(div) && div >= DIV_W'(2) |=> !tick)
        else $error("divider tick repeated too soon");

endmodule // pcrsd_divider

`default_nettype wire

// ===== design/pcrsd_detect.sv
//
// Behaviour
// - accept 32-48, 64-96 and 128-192 kHz families in the three modes
// - serial samples are two's complement, source encodes them so
// - frame clock level tells which channel the arriving bits belong to
// - serial bits shift into the input buffer on the bit clock
// - settings from mode pins in hardware config, from registers in software
// - count master cycles per frame period and measure master rate
// - program internal dividers once ratio and mode are known
// - single rate: 256x to 1024x, plus 1152x at 32 kHz
// - double rate: 128x, 192x, 256x, 384x, 512x
// - quad rate: 64x, 96x, 128x, 192x, 256x
// - some manual combinations are not recognised by auto detect
// - auto bands: 4-54, 84-108, 170-216 kHz
// - oversample 128x single, 64x double, 32x quad
//
`timescale 1ns/1ps
`default_nettype none

module pcrsd_detect
    import pcrsd_pkg::*;
#(
    parameter int LINES = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic frame_clock,
    input wire logic bit_clock,
    input wire logic [LINES-1:0] serial_data_inputs,
    input wire logic ref_tick,
    input wire logic sw_config,
    input wire logic [4:0] mode_select_pins,
    input wire logic [1:0] sw_speed_sel,
    output var pcrsd_clkcfg_s cfg,
    output logic [CNT_W-1:0] ratio_out,
    output logic ctrl_ready,
    output logic sample_valid,
    output var pcrsd_sample_s samples [LINES],
    output logic div_tick
);

    // ------------------------------------------------------------
    // edge detection and measurement counters
    // ------------------------------------------------------------
    logic frame_prev_reg;
    logic bit_prev_reg;
    logic [CNT_W-1:0] per_cnt_reg;
    logic [CNT_W-1:0] ref_cnt_reg;
    logic [CNT_W-1:0] rate_cnt_reg;
    logic have_rate_reg;
    pcrsd_state_e st_reg;
    pcrsd_state_e st_next;
    pcrsd_clkcfg_s cfg_next;
    logic [WAIT_W-1:0] wait_cnt_reg;

    wire logic frame_rise = frame_clock && !frame_prev_reg;
    wire logic frame_edge = frame_clock != frame_prev_reg;
    wire logic bit_rise = bit_clock && !bit_prev_reg;
    wire logic per_sat = &per_cnt_reg;
    wire logic ref_sat = &ref_cnt_reg;

    // cycle count since the previous rising frame edge is the ratio
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            frame_prev_reg <= 1'b0;
            bit_prev_reg <= 1'b0;
            per_cnt_reg <= '0;
            ref_cnt_reg <= '0;
            rate_cnt_reg <= '0;
            have_rate_reg <= 1'b0;
        end else begin
            frame_prev_reg <= frame_clock;
            bit_prev_reg <= bit_clock;
            per_cnt_reg <= frame_rise ? CNT_W'(1) : per_cnt_reg + CNT_W'(!per_sat);
            ref_cnt_reg <= ref_tick ? CNT_W'(1) : ref_cnt_reg + CNT_W'(!ref_sat);
            if (ref_tick) begin
                rate_cnt_reg <= ref_cnt_reg;
                have_rate_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // ratio and speed decode
    // ------------------------------------------------------------
    wire logic [CNT_W-1:0] ratio = per_cnt_reg;
    wire logic [2:0] pin_sel = mode_select_pins[4:2];
    wire logic auto_sel = sw_config ? (sw_speed_sel == SWSEL_AUTO)
                                    : (pin_sel == MSEL_AUTO || pin_sel == MSEL_AUTO_DEM);
    wire logic man_single = sw_config ? (sw_speed_sel == SWSEL_SINGLE)
                                      : (pin_sel == MSEL_SINGLE || pin_sel == MSEL_SINGLE_DEM);
    wire logic man_double = sw_config ? (sw_speed_sel == SWSEL_DOUBLE) : (pin_sel == MSEL_DOUBLE);
    wire logic man_quad = sw_config ? (sw_speed_sel == SWSEL_QUAD) : (pin_sel == MSEL_QUAD);

    // auto detect only inside its own frame-rate bands
    wire logic r1152_ok = (ratio == R1152) && in_band(ratio, rate_cnt_reg, R1152_LO_KHZ, R1152_HI_KHZ);
    wire logic auto_single = (single_ratio(ratio) && in_band(ratio, rate_cnt_reg, SSM_LO_KHZ, SSM_HI_KHZ))
                             || r1152_ok;
    wire logic auto_double = double_ratio(ratio)
                             && in_band(ratio, rate_cnt_reg, DSM_LO_KHZ, DSM_HI_KHZ);
    wire logic auto_quad = quad_ratio(ratio)
                           && in_band(ratio, rate_cnt_reg, QSM_LO_KHZ, QSM_HI_KHZ);

    wire logic pick_single = auto_sel ? auto_single
                                      : man_single && (single_ratio(ratio) || ratio == R1152);
    wire logic pick_double = auto_sel ? auto_double : man_double && double_ratio(ratio);
    wire logic pick_quad = auto_sel ? auto_quad : man_quad && quad_ratio(ratio);
    wire logic match = have_rate_reg && (pick_single || pick_double || pick_quad);

    // divider = ratio / oversampling
    wire pcrsd_speed_e new_speed = pick_single ? PCRSD_SPD_SINGLE
                                 : pick_double ? PCRSD_SPD_DOUBLE : PCRSD_SPD_QUAD;
    wire logic [OS_W-1:0] new_os = pick_single ? OS_SINGLE : pick_double ? OS_DOUBLE : OS_QUAD;
    wire logic [CNT_W-1:0] new_quot = pick_single ? ratio >> OS_SH_SINGLE
                                    : pick_double ? ratio >> OS_SH_DOUBLE : ratio >> OS_SH_QUAD;
    wire logic [DIV_W-1:0] new_div = new_quot[DIV_W-1:0];
    wire logic eval = frame_rise && (st_reg != PCRSD_ST_INIT);

    // ------------------------------------------------------------
    // lock state machine
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        cfg_next = cfg;
        unique case (st_reg)
            PCRSD_ST_INIT: begin
                // first period is partial, discard it
                if (frame_rise) begin
                    st_next = PCRSD_ST_MEASURE;
                end
            end
            PCRSD_ST_MEASURE, PCRSD_ST_LOCKED: begin
                if (eval && match) begin
                    st_next = PCRSD_ST_LOCKED;
                    cfg_next = '{speed: new_speed, os: new_os, div: new_div, valid: 1'b1};
                end else if (eval) begin
                    st_next = PCRSD_ST_MEASURE;
                    cfg_next.valid = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= PCRSD_ST_INIT;
            cfg <= '{speed: PCRSD_SPD_SINGLE, os: OS_SINGLE, div: DIV_W'(2), valid: 1'b0};
            ratio_out <= '0;
        end else begin
            st_reg <= st_next;
            cfg <= cfg_next;
            if (eval && match) begin
                ratio_out <= ratio;
            end
        end
    end

    pcrsd_divider u_div (
        .clk(clk),
        .arst_n(arst_n),
        .enable(cfg.valid),
        .div(cfg.div),
        .tick(div_tick)
    );

    // ------------------------------------------------------------
    // control port wait after reset
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wait_cnt_reg <= '0;
            ctrl_ready <= 1'b0;
        end else begin
            if (!ctrl_ready) begin
                wait_cnt_reg <= wait_cnt_reg + WAIT_W'(1);
            end
            ctrl_ready <= ctrl_ready || (wait_cnt_reg == WAIT_W'(CTRL_WAIT_CYC - 1));
        end
    end

    // ------------------------------------------------------------
    // serial input buffer
    // ------------------------------------------------------------
    logic [31:0] shift_reg [LINES];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= frame_edge;
        end
    end

    for (genvar g = 0; g < LINES; g++) begin : g_line
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                shift_reg[g] <= '0;
                samples[g] <= '0;
            end else begin
                if (bit_rise) begin
                    shift_reg[g] <= {shift_reg[g][30:0], serial_data_inputs[g]};
                end
                if (frame_edge) begin
                    // word kept as two's complement
                    samples[g].word <= $signed(shift_reg[g]);
                    samples[g].right <= frame_prev_reg;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    chk_ratio_capture: assert property (
        eval && match |=> ratio_out == $past(per_cnt_reg) && cfg.valid)
        else $error("ratio not captured on lock");
    chk_nomatch_hold: assert property (
        eval && !match |=> !cfg.valid && cfg.div == $past(cfg.div) && st_reg == PCRSD_ST_MEASURE)
        else $error("unmatched period changed divider");
    chk_div_program: assert property (
        eval && match |=> cfg.div == $past(new_div) && cfg.div >= DIV_W'(2))
        else $error("divider not programmed");
    chk_os_speed: assert property (
        cfg.valid |-> (cfg.speed == PCRSD_SPD_SINGLE) == (cfg.os == OS_SINGLE)
                   && (cfg.speed == PCRSD_SPD_QUAD) == (cfg.os == OS_QUAD))
        else $error("oversampling does not fit speed");
    chk_ratio_set: assert property (
        cfg.valid |-> (cfg.speed != PCRSD_SPD_QUAD || quad_ratio(ratio_out))
                   && (cfg.speed != PCRSD_SPD_DOUBLE || double_ratio(ratio_out)))
        else $error("locked on unsupported ratio");
    chk_auto_band: assert property (
        eval && auto_sel && single_ratio(ratio) && !quad_ratio(ratio) && !double_ratio(ratio)
        && !in_band(ratio, rate_cnt_reg, SSM_LO_KHZ, SSM_HI_KHZ) |=> !cfg.valid)
        else $error("auto locked outside band");
    chk_ctrl_wait: assert property (
        $rose(arst_n) |-> !ctrl_ready [*8])
        else $error("control ready too early");
    chk_shift_bit: assert property (
        bit_rise |=> shift_reg[0][0] == $past(serial_data_inputs[0]))
        else $error("bit not shifted in");
    chk_sample_chan: assert property (
        frame_edge |=> sample_valid && samples[0].right == !frame_clock ##1 !sample_valid || $past(frame_edge))
        else $error("sample channel wrong");

    cov_lock_single: cover property (eval && match && pick_single);
    cov_lock_quad: cover property (eval && match && pick_quad);
    cov_retry: cover property (cfg.valid ##1 !cfg.valid);
    cov_sample: cover property (sample_valid && samples[0].right);

endmodule // pcrsd_detect

`default_nettype wire

// ===== test/pcrsd_src_model.sv
`timescale 1ns/1ps
`default_nettype none

module pcrsd_src_model
    import pcrsd_pkg::*;
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [CNT_W-1:0] period,
    output logic frame_clock,
    output logic bit_clock,
    output logic [3:0] sdata,
    output logic [3:0][31:0] exp_word,
    output logic exp_right
);
    int seed = 8;
    logic [CNT_W-1:0] cnt, per, nxt;
    logic lvl;
    logic [3:0][31:0] shadow;

    // ------------------------------------------------------------
    // source clocks and data, all stepped from the master clock
    // ------------------------------------------------------------
    always @(negedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= '0;
            per <= period;
            frame_clock <= 1'b0;
            bit_clock <= 1'b0;
            sdata <= '0;
            shadow <= '0;
            exp_word <= '0;
            exp_right <= 1'b0;
        end else begin
            nxt = (cnt == per - 12'h001) ? 12'h000 : cnt + 12'h001;
            lvl = (nxt >= (per >> 1));
            cnt <= nxt;
            if (nxt == 12'h000) begin
                per <= period;
            end
            bit_clock <= nxt[0];
            frame_clock <= lvl;
            if (nxt[0]) begin
                for (int l = 0; l < 4; l++) begin
                    shadow[l] <= {shadow[l][30:0], sdata[l]};
                end
            end else begin
                sdata <= 4'($random(seed));
            end
            // frame edges only fall on even counts, away from bit rises
            if (lvl != frame_clock) begin
                exp_word <= shadow;
                exp_right <= frame_clock;
            end
        end
    end
endmodule // pcrsd_src_model

`default_nettype wire

// ===== test/tb_pcm_clock_ratio_speed_detect.sv
`timescale 1ns/1ps
`default_nettype none

module tb_pcm_clock_ratio_speed_detect
    import pcrsd_pkg::*;
;
    localparam pcrsd_clkcfg_s RST_CFG = '{PCRSD_SPD_SINGLE, OS_SINGLE, 4'h2, 1'b0};
    localparam int LIMIT = 100000;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic ref_tick = 1'b0;
    logic sw_config = 1'b0;
    logic [4:0] mode_select_pins = 5'h18;
    logic [1:0] sw_speed_sel = 2'h0;
    logic [CNT_W-1:0] frame_period = 12'h100;
    logic frame_clock, bit_clock, ctrl_ready, sample_valid, div_tick, exp_right;
    logic [3:0] sdata;
    logic [3:0][31:0] exp_word;
    logic [CNT_W-1:0] ratio_out, exp_ratio;
    pcrsd_clkcfg_s cfg, exp_cfg, cfg_last;
    pcrsd_sample_s samples [4];
    int seed = 8;
    int fail_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int ref_period = 122;
    int rcnt = 0;
    int gap = 0;
    int sel, n, r;
    bit armed = 1'b0;
    int ratios [9] = '{64, 96, 128, 192, 256, 384, 512, 768, 1024};
    // mode code (0..7 pins, 8..11 software), frame period, ref period
    int cases [18][3] = '{'{4, 256, 122}, '{4, 128, 122}, '{4, 64, 122}, '{5, 96, 184},
        '{4, 1152, 368}, '{4, 1152, 552}, '{4, 1024, 40}, '{4, 1024, 41}, '{11, 512, 276},
        '{2, 512, 491}, '{3, 256, 491}, '{0, 1152, 552}, '{1, 768, 100}, '{6, 256, 122},
        '{9, 192, 184}, '{10, 96, 184}, '{8, 384, 184}, '{4, 300, 150}};

    pcrsd_detect #(.LINES(4)) uut (
        .clk(clk), .arst_n(arst_n), .frame_clock(frame_clock), .bit_clock(bit_clock),
        .serial_data_inputs(sdata), .ref_tick(ref_tick), .sw_config(sw_config),
        .mode_select_pins(mode_select_pins), .sw_speed_sel(sw_speed_sel), .cfg(cfg),
        .ratio_out(ratio_out), .ctrl_ready(ctrl_ready), .sample_valid(sample_valid),
        .samples(samples), .div_tick(div_tick)
    );

    pcrsd_src_model src (
        .clk(clk), .arst_n(arst_n), .period(frame_period), .frame_clock(frame_clock),
        .bit_clock(bit_clock), .sdata(sdata), .exp_word(exp_word), .exp_right(exp_right)
    );

    // ------------------------------------------------------------
    // clock, timebase and watchdog
    // ------------------------------------------------------------
    initial begin
        forever #10 clk = ~clk;
    end

    always @(negedge clk) begin
        rcnt = (rcnt + 1 >= ref_period) ? 0 : rcnt + 1;
        ref_tick <= (rcnt == 0);
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc >= LIMIT) begin
            fail_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function automatic pcrsd_clkcfg_s predict(input pcrsd_clkcfg_s prev, input int s,
                                              input int fn, input int fr);
        int m, f;
        logic s_ok, d_ok, q_ok;
        pcrsd_clkcfg_s res;
        f = fr * 100;
        m = (s >= 8) ? s - 8 : (s < 2) ? 0 : (s < 4) ? s - 1 : (s < 6) ? 3 : 4;
        s_ok = (fn inside {256, 384, 512, 768, 1024} && (m == 0 || (m == 3 && fn * 4 <= f
                && f <= fn * 54))) || (fn == 1152 && (m == 0 || (m == 3 && fn * 30 <= f
                && f <= fn * 34)));
        d_ok = fn inside {128, 192, 256, 384, 512} && (m == 1 || (m == 3 && fn * 84 <= f
               && f <= fn * 108));
        q_ok = fn inside {64, 96, 128, 192, 256} && (m == 2 || (m == 3 && fn * 170 <= f
               && f <= fn * 216));
        res = prev;
        res.valid = 1'b0;
        if (s_ok) begin
            res = '{PCRSD_SPD_SINGLE, OS_SINGLE, DIV_W'(fn / 128), 1'b1};
        end else if (d_ok) begin
            res = '{PCRSD_SPD_DOUBLE, OS_DOUBLE, DIV_W'(fn / 64), 1'b1};
        end else if (q_ok) begin
            res = '{PCRSD_SPD_QUAD, OS_QUAD, DIV_W'(fn / 32), 1'b1};
        end
        return res;
    endfunction

    task automatic do_reset();
        arst_n = 1'b0;
        repeat (6) @(negedge clk);
        check("rst_cfg", 32'(cfg), 32'(RST_CFG));
        check("rst_ratio", 32'(ratio_out), 32'h0);
        check("rst_flags", {29'h0, sample_valid, div_tick, ctrl_ready}, 32'h0);
        check("rst_word", samples[0].word, 32'h0);
        arst_n = 1'b1;
        repeat (24) @(negedge clk);
        check("ctrl_ready_early", 32'(ctrl_ready), 32'h0);
        @(negedge clk);
        check("ctrl_ready", 32'(ctrl_ready), 32'h1);
        exp_cfg = RST_CFG;
        exp_ratio = '0;
    endtask

    // park in a code that matches nothing, let clocks settle, then select the mode
    task automatic run_case(input int s, input int fn, input int fr);
        int extra;
        // a longer old frame must run out before the new period applies
        extra = (int'(frame_period) > fn) ? int'(frame_period) : 0;
        sw_config = 1'b0;
        mode_select_pins = {3'h6, 2'($random(seed))};
        sw_speed_sel = 2'($random(seed));
        frame_period = 12'(fn);
        ref_period = fr;
        repeat (2 * fr + 3 * fn + 8 + extra) @(negedge clk);
        exp_cfg.valid = 1'b0;
        check("park_cfg", 32'(cfg), 32'(exp_cfg));
        check("park_ratio", 32'(ratio_out), 32'(exp_ratio));
        sw_config = (s >= 8);
        sw_speed_sel = 2'(s);
        mode_select_pins = {3'(s), 2'($random(seed))};
        repeat (2 * fn + 4) @(negedge clk);
        exp_cfg = predict(exp_cfg, s, fn, fr);
        if (exp_cfg.valid) begin
            exp_ratio = 12'(fn);
        end
        check("cfg", 32'(cfg), 32'(exp_cfg));
        check("ratio_out", 32'(ratio_out), 32'(exp_ratio));
    endtask

    // ------------------------------------------------------------
    // monitors: serial words and divider pulses
    // ------------------------------------------------------------
    always @(negedge clk) begin
        gap++;
        if (cfg !== cfg_last || arst_n !== 1'b1) begin
            armed = 1'b0;
            cfg_last = cfg;
        end
        if (arst_n === 1'b1 && div_tick === 1'b1) begin
            if (armed && cfg.valid === 1'b1) begin
                check("div_gap", 32'(gap), 32'(cfg.div));
            end
            armed = 1'b1;
            gap = 0;
        end
        if (arst_n === 1'b1 && sample_valid === 1'b1) begin
            for (int l = 0; l < 4; l++) begin
                check("sample_word", samples[l].word, exp_word[l]);
                check("sample_right", 32'(samples[l].right), 32'(exp_right));
            end
            check("sample_sign", 32'(samples[0].word < 0), 32'(exp_word[0][31]));
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        do_reset();
        foreach (cases[i]) begin
            run_case(cases[i][0], cases[i][1], cases[i][2]);
        end
        do_reset();
        repeat (6) begin
            sel = int'($unsigned($random(seed)) % 12);
            n = ratios[$unsigned($random(seed)) % 9];
            r = 20 + int'($unsigned($random(seed)) % 560);
            run_case(sel, n, r);
        end
        print_verdict();
    end
endmodule // tb_pcm_clock_ratio_speed_detect

`default_nettype wire
